// File: logic/acl_current_loop.sv
// Armature current loop: gains, firing-angle computation, standstill,
// bridge changeover and 12-pulse routing, with a plain register port.
// Assumes loop_in comes from logic on clk_sys; supply_sync and
// lockout_input are pins and are synchronised here.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module acl_current_loop
  import acl_pkg::*;
#(
  parameter int unsigned RELAY_CYCLES = RELAY_OPEN_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          clk_en,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire acl_loop_in_t  loop_in,
  input  wire logic          supply_sync,
  input  wire logic          lockout_input,
  output acl_gate_out_t      gate_out,
  output logic               lockout_output
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic signed [23:0] gterm(input logic signed [12:0] e,
                                               input logic [7:0] g, input int sh);
    gterm = (24'(e) * $signed({16'h0000, g})) >>> sh;
  endfunction

  function automatic logic [9:0] clamp_ang(input logic signed [23:0] v);
    if (v < 24'(ANGLE_MIN)) begin
      clamp_ang = 10'(ANGLE_MIN);
    end else if (v > 24'(ANGLE_MAX)) begin
      clamp_ang = 10'(ANGLE_MAX);
    end else begin
      clamp_ang = v[9:0];
    end
  endfunction

  function automatic logic in_range(input logic signed [23:0] v);
    in_range = (v >= 24'(ANGLE_MIN)) && (v <= 24'(ANGLE_MAX));
  endfunction

  function automatic logic [7:0] rd_mux(input logic [3:0] a, input acl_state_t s);
    case (a)
      OFS_KID:    rd_mux = s.kid;
      OFS_KP:     rd_mux = s.kp;
      OFS_KI:     rd_mux = s.ki;
      OFS_KMC:    rd_mux = s.kmc;
      OFS_CTRL0:  rd_mux = s.ctrl0;
      OFS_CTRL1:  rd_mux = s.ctrl1;
      OFS_STAT:   rd_mux = {3'h0, s.ss_off, s.relay_open, s.br_st != BR_RUN,
                            s.bridge, s.series_act};
      OFS_ANG_LO: rd_mux = s.angle[7:0];
      OFS_ANG_HI: rd_mux = {6'h00, s.angle[9:8]};
      default:    rd_mux = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Derived terms
  // ---------------------------------------------------------------
  acl_state_t q;
  acl_state_t d;
  logic                tick;
  logic                inh;
  logic                ss_arm;
  logic                lk_blk;
  logic                disc;
  logic                cat_run;
  logic                fire;
  logic                at_load;
  logic signed [13:0]  fb_x5;
  logic signed [11:0]  fb_s;
  logic signed [11:0]  dem_e;
  logic signed [11:0]  fb_e;
  logic signed [11:0]  hyst;
  logic signed [12:0]  err;
  logic signed [12:0]  err_abs;
  logic signed [12:0]  dem_pos;
  logic signed [23:0]  ang_c;
  logic signed [23:0]  ang_d;

  // Edge of the second synchroniser stage; the first stage feeds nothing else.
  assign tick = q.sup2 & ~q.sup3;
  assign inh  = q.ctrl0[C0_INHIBIT];
  assign fb_x5 = 14'(loop_in.fb) * 14'sh005;
  assign fb_s  = q.ctrl1[C1_INC_FB] ? 12'(fb_x5 >>> 3) : 12'(loop_in.fb);
  assign dem_e = q.bridge ? -12'(loop_in.demand) : 12'(loop_in.demand);
  assign fb_e  = q.bridge ? -fb_s : fb_s;
  assign err   = 13'(dem_e) - 13'(fb_e);
  assign err_abs = err[12] ? -err : err;
  assign dem_pos = dem_e[11] ? 13'sh0000 : 13'(dem_e);
  assign hyst = q.ctrl1[C1_RED_HYST] ? HYST_RED : HYST_NORM;
  assign ss_arm = q.ctrl0[C0_SS_EN]
                  && (loop_in.stop_cmd || (!q.ctrl0[C0_SS_TRIG] && loop_in.zero_ref))
                  && (12'(loop_in.speed) < SPEED_STILL)
                  && (12'(loop_in.speed) > -SPEED_STILL);
  assign lk_blk = q.ctrl0[C0_LOCKOUT] && q.ctrl0[C0_PARALLEL] && q.lko2;
  assign disc = !q.ctrl0[C0_ADAPT_DIS] && (fb_e < CONT_THRESH);
  assign cat_run = q.ctrl1[C1_CAT_EN] && !loop_in.spillover && !q.series_act;
  assign fire = !inh && (q.br_st == BR_RUN) && !q.ss_off;
  assign at_load = loop_in.autotune_done && q.ctrl1[C1_STARTUP_AT] && !q.relay_open;
  assign ang_c = 24'(ANGLE_MIN) + (q.acc_c >>> KI_SHIFT) + gterm(err, q.kp, KP_SHIFT);
  assign ang_d = 24'(ANGLE_MIN) + gterm(dem_pos, q.kmc, KMC_SHIFT)
                 + (q.acc_d >>> KID_SHIFT);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.sup1 = supply_sync;
    d.sup2 = q.sup1;
    d.sup3 = q.sup2;
    d.lko1 = lockout_input;
    d.lko2 = q.lko1;
    d.rdata = reg_rd ? rd_mux(reg_addr, q) : 8'h00;
    d.fire_b1  = fire && !q.bridge;
    d.fire_b2  = fire && q.bridge && !q.series_act;
    d.fire_dly = fire && !q.bridge && q.series_act;
    d.ramp_rst = inh;
    // Conducting is advertised to the partner while our gates are live.
    d.lko_out  = fire;
    if (loop_in.cyclic_reset) begin
      if (loop_in.b2_quadrant) begin
        d.series_act = 1'b0;
        d.ctrl0[C0_SERIES] = 1'b0;
      end else begin
        d.series_act = q.ctrl0[C0_SERIES];
      end
    end
    if (tick) begin
      case (q.br_st)
        BR_RUN: begin
          if (dem_e < -hyst) begin
            d.br_st = BR_WAIT;
          end
        end
        BR_WAIT: begin
          if (fb_e <= 12'sh000 && !lk_blk) begin
            d.br_st = BR_GAP;
            d.bridge = !q.bridge;
            d.acc_c = '0;
            d.acc_d = '0;
            d.gap_cnt = q.ctrl1[C1_EXTRA_SAFE] ? GAP_BASE + GAP_EXTRA : GAP_BASE;
          end
        end
        BR_GAP: begin
          d.gap_cnt = q.gap_cnt - 2'h1;
          if (q.gap_cnt <= 2'h1) begin
            d.br_st = BR_RUN;
          end
        end
        default: d.br_st = BR_RUN;
      endcase
      if (ss_arm) begin
        if (q.ss_cnt < SS_DELAY_TICKS) begin
          d.ss_cnt = q.ss_cnt + 3'h1;
        end
        d.ss_off = (q.ss_cnt >= SS_DELAY_TICKS - 3'h1);
      end else begin
        d.ss_cnt = 3'h0;
        d.ss_off = 1'b0;
      end
      if (inh || ss_arm || q.br_st != BR_RUN) begin
        d.angle = 10'(ANGLE_MIN);
        if (inh) begin
          d.acc_c = '0;
          d.acc_d = '0;
        end
      end else if (q.ctrl0[C0_DIRECT]) begin
        d.angle = clamp_ang(24'(loop_in.ref_post));
      end else if (disc) begin
        d.angle = clamp_ang(ang_d);
        // Integrate only while unclamped so the store cannot wind up.
        if (in_range(ang_d)) begin
          d.acc_d = q.acc_d + gterm(err, q.kid, 0);
        end
      end else begin
        d.angle = clamp_ang(ang_c);
        if (in_range(ang_c)) begin
          d.acc_c = q.acc_c + gterm(err, q.ki, 0);
        end
      end
      if (cat_run && !disc && !inh) begin
        if (err_abs > AT_RIPPLE_HI && q.kp != 8'hff) begin
          d.kp = q.kp + 8'h01;
        end else if (err_abs < AT_RIPPLE_LO && q.kp != 8'h00) begin
          d.kp = q.kp - 8'h01;
        end
      end
    end
    if (at_load) begin
      d.kid = loop_in.at_kid;
      d.kp = loop_in.at_kp;
      d.ki = loop_in.at_ki;
      d.kmc = loop_in.at_kmc;
      d.relay_open = 1'b1;
      d.relay_cnt = '0;
    end else if (q.relay_open) begin
      d.relay_cnt = q.relay_cnt + 23'h000001;
      if (q.relay_cnt >= 23'(RELAY_CYCLES - 1)) begin
        d.relay_open = 1'b0;
        d.ctrl1[C1_STARTUP_AT] = 1'b0;
      end
    end
    // A software write in the same cycle wins over hardware updates.
    if (reg_wr) begin
      case (reg_addr)
        OFS_KID:   d.kid = reg_wdata;
        OFS_KP:    d.kp = reg_wdata;
        OFS_KI:    d.ki = reg_wdata;
        OFS_KMC:   d.kmc = reg_wdata;
        OFS_CTRL0: d.ctrl0 = reg_wdata;
        OFS_CTRL1: d.ctrl1 = reg_wdata & CTRL1_MASK;
        default:   d.rdata = d.rdata;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q <= ST_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign lockout_output = q.lko_out;
  assign gate_out = '{angle: q.angle, fire_b1: q.fire_b1, fire_b2: q.fire_b2,
                      fire_delayed: q.fire_dly, ramp_reset: q.ramp_rst,
                      relay_open: q.relay_open};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_inhibit_no_fire:
    assert property (inh && clk_en |=> !gate_out.fire_b1 && !gate_out.fire_b2
                     && gate_out.ramp_reset)
    else $error("firing while inhibited");
  a_angle_legal_range:
    assert property (gate_out.angle >= 10'(ANGLE_MIN))
    else $error("firing angle below legal range");
  a_direct_from_ref:
    assert property (tick && clk_en && q.ctrl0[C0_DIRECT] && !inh && !ss_arm
                     && q.br_st == BR_RUN
                     |=> gate_out.angle == clamp_ang(24'($past(loop_in.ref_post))))
    else $error("direct angle does not follow reference");
  a_standstill_phase_back:
    assert property (tick && clk_en && ss_arm |=> gate_out.angle == 10'(ANGLE_MIN))
    else $error("standstill did not phase back");
  a_series_cleared_b2:
    assert property (loop_in.cyclic_reset && loop_in.b2_quadrant && clk_en && !reg_wr
                     |=> !q.series_act && !q.ctrl0[C0_SERIES])
    else $error("series setting kept with bridge 2 enabled");
  a_delayed_needs_series:
    assert property (gate_out.fire_delayed && $past(clk_en) |-> $past(q.series_act)
                     && !gate_out.fire_b2)
    else $error("delayed set without series mode");
  a_ki_untouched_by_tune:
    assert property (!(reg_wr && reg_addr == OFS_KI) && !at_load |=> $stable(q.ki))
    else $error("continuous integral gain changed");
  a_tune_held_spill:
    assert property (loop_in.spillover && !reg_wr && !at_load |=> $stable(q.kp))
    else $error("autotune ran during spill-over");
  a_tune_held_series:
    assert property (q.series_act && !reg_wr && !at_load |=> $stable(q.kp))
    else $error("autotune ran in series mode");
  a_lockout_blocks_swap:
    assert property (q.br_st == BR_WAIT && lk_blk |=> q.br_st != BR_GAP)
    else $error("bridge change while partner conducts");
  a_hyst_holds_bridge:
    assert property (tick && clk_en && q.br_st == BR_RUN && dem_e >= -hyst
                     |=> q.br_st == BR_RUN && $stable(q.bridge))
    else $error("bridge change inside hysteresis");
  a_relay_ends_clear:
    assert property ($fell(q.relay_open) && !$past(reg_wr) |-> !q.ctrl1[C1_STARTUP_AT])
    else $error("autotune enable not cleared");
  a_inhibit_clears_acc:
    assert property (tick && clk_en && inh |=> q.acc_c == '0 && q.acc_d == '0)
    else $error("integrators kept while inhibited");
  a_changeover_no_fire:
    assert property (q.br_st != BR_RUN && clk_en |=> !gate_out.fire_b1 && !gate_out.fire_b2
                     && !gate_out.fire_delayed)
    else $error("firing during bridge changeover");
  a_lockout_out_live:
    assert property (gate_out.fire_b1 || gate_out.fire_b2 |-> lockout_output)
    else $error("conduction not advertised to partner");

  c_bridge_gap:   cover property (tick && q.br_st == BR_GAP);
  c_standstill:   cover property ($rose(q.ss_off));
  c_relay_open:   cover property ($rose(q.relay_open));
  c_delayed_fire: cover property (gate_out.fire_delayed);
  c_adaptive_off: cover property (tick && q.ctrl0[C0_ADAPT_DIS] && q.br_st == BR_RUN);

endmodule

// File: pkg/acl_pkg.sv
// Constants and types for the armature current loop control block.
// Assumes a 125 MHz system clock and one supply-cycle tick from a pin.
package acl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ    = 32'h0773_5940;
  localparam int RELAY_OPEN_MS  = 32'h32;
  localparam int RELAY_OPEN_CYC = CLK_FREQ_HZ / 32'h3e8 * RELAY_OPEN_MS;
  localparam logic [2:0] SS_DELAY_TICKS = 3'h4;
  localparam logic [1:0] GAP_BASE = 2'h1;
  localparam logic [1:0] GAP_EXTRA = 2'h1;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_KID = 4'h0, OFS_KP = 4'h1, OFS_KI = 4'h2;
  localparam logic [3:0] OFS_KMC = 4'h3, OFS_RSVD = 4'h4;
  localparam logic [3:0] OFS_CTRL0 = 4'h5, OFS_CTRL1 = 4'h6;
  localparam logic [3:0] OFS_STAT = 4'h7, OFS_ANG_LO = 4'h8, OFS_ANG_HI = 4'h9;
  localparam int C0_INHIBIT = 0, C0_SS_EN = 1, C0_SS_TRIG = 2, C0_DIRECT = 3;
  localparam int C0_LOCKOUT = 4, C0_ADAPT_DIS = 5, C0_SERIES = 6, C0_PARALLEL = 7;
  localparam int C1_EXTRA_SAFE = 0, C1_CAT_EN = 1, C1_RED_HYST = 2;
  localparam int C1_INC_FB = 3, C1_STARTUP_AT = 4;
  localparam logic [7:0] CTRL1_MASK = 8'h1f;
  localparam logic [7:0] KID_RST = 8'h10, KP_RST = 8'h10, KI_RST = 8'h10;
  localparam logic [7:0] KMC_RST = 8'h19, CTRL0_RST = 8'h02, CTRL1_RST = 8'h00;

  // ---------------------------------------------------------------
  // Loop scaling
  // ---------------------------------------------------------------
  localparam int KID_SHIFT = 7, KP_SHIFT = 8, KI_SHIFT = 9, KMC_SHIFT = 5;
  localparam int ANGLE_MIN = 32'h115;
  localparam int ANGLE_MAX = 32'h3ff;
  localparam logic signed [11:0] SPEED_STILL = 12'sh008;
  localparam logic signed [11:0] HYST_NORM = 12'sh010;
  localparam logic signed [11:0] HYST_RED = 12'sh002;
  localparam logic signed [11:0] CONT_THRESH = 12'sh05c;
  localparam logic signed [12:0] AT_RIPPLE_HI = 13'sh0020;
  localparam logic signed [12:0] AT_RIPPLE_LO = 13'sh0008;

  typedef enum logic [1:0] {BR_RUN = 2'b00, BR_WAIT = 2'b01, BR_GAP = 2'b10} acl_br_st_t;

  typedef struct packed {
    logic signed [10:0] demand;
    logic signed [10:0] fb;
    logic signed [10:0] ref_post;
    logic signed [10:0] speed;
    logic stop_cmd, zero_ref, spillover, cyclic_reset, b2_quadrant, autotune_done;
    logic [7:0] at_kid, at_kp, at_ki, at_kmc;
  } acl_loop_in_t;

  typedef struct packed {
    logic [9:0] angle;
    logic fire_b1, fire_b2, fire_delayed, ramp_reset, relay_open;
  } acl_gate_out_t;

  typedef struct packed {
    logic sup1, sup2, sup3, lko1, lko2;
    logic [7:0] kid, kp, ki, kmc, ctrl0, ctrl1;
    logic series_act, bridge;
    acl_br_st_t br_st;
    logic [1:0] gap_cnt;
    logic [2:0] ss_cnt;
    logic ss_off;
    logic signed [23:0] acc_c, acc_d;
    logic [9:0] angle;
    logic fire_b1, fire_b2, fire_dly, ramp_rst, lko_out, relay_open;
    logic [22:0] relay_cnt;
    logic [7:0] rdata;
  } acl_state_t;

  localparam acl_state_t ST_RST = '{kid: KID_RST, kp: KP_RST, ki: KI_RST, kmc: KMC_RST,
    ctrl0: CTRL0_RST, ctrl1: CTRL1_RST, br_st: BR_RUN, angle: 10'(ANGLE_MIN), default: '0};

endpackage

// File: verif/acl_gate_model.sv
// Stand-in for the far side: free-running supply sync and the gate pulse generator.
// Assumes gate_out is registered on clk_sys; the mains never stops, so neither does sync.
`timescale 1ns/10ps
module acl_gate_model
  import acl_pkg::*;
#(
  parameter int HALF = 32
) (
  input  wire logic          clk_sys,
  input  wire acl_gate_out_t gate_out,
  input  wire logic          partner_busy,
  output logic               supply_sync,
  output logic               lockout_input,
  output int                 fire_cnt
);
  int ph;

  initial begin
    ph = 0;
    supply_sync = 1'b0;
    fire_cnt = 0;
  end

  always @(posedge clk_sys) begin
    ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
    supply_sync <= (ph < HALF);
    if (gate_out.fire_b1 | gate_out.fire_b2 | gate_out.fire_delayed) begin
      fire_cnt <= fire_cnt + 1;
    end
  end

  assign lockout_input = partner_busy;
endmodule

// File: verif/armature_current_loop_control_test.sv
// Self-checking bench for the current loop block and its far-side model.
// Assumes 125 MHz clk_sys; a supply cycle is shortened to 64 clocks.
`timescale 1ns/10ps
module armature_current_loop_control_test;
  import acl_pkg::*;
  localparam int PER = 64;
  logic          clk_sys = 1'b0;
  logic          resetn = 1'b0;
  logic          clk_en = 1'b1;
  logic [3:0]    reg_addr = 4'h0;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [7:0]    reg_rdata;
  acl_loop_in_t  li = '0;
  logic          supply_sync;
  logic          lockout_input;
  logic          partner_busy = 1'b0;
  acl_gate_out_t gate_out;
  logic          lockout_output;
  logic          rd_seen = 1'b0;
  int            fire_cnt;
  int            n_fail = 0;
  int            n_compared = 0;
  int            i;
  int            k;
  int            v;
  logic [9:0]    ea;
  logic [7:0]    gv [4];
  logic [15:0]   exp_q [$];

  always #4 clk_sys = ~clk_sys;

  acl_current_loop #(.RELAY_CYCLES(20)) u_acl_current_loop (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .loop_in(li), .supply_sync(supply_sync), .lockout_input(lockout_input),
    .gate_out(gate_out), .lockout_output(lockout_output));

  acl_gate_model #(.HALF(PER / 2)) u_acl_gate_model (
    .clk_sys(clk_sys), .gate_out(gate_out), .partner_busy(partner_busy),
    .supply_sync(supply_sync), .lockout_input(lockout_input), .fire_cnt(fire_cnt));

  task automatic results();
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // The note goes on the queue; the monitor below compares under the mask.
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic ticks(input int n);
    repeat (n * PER) @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------
  // Read-data monitor
  // ---------------------------------------------------------------
  always @(posedge clk_sys) rd_seen <= reg_rd;

  always @(negedge clk_sys) begin
    logic [15:0] e;
    if (rd_seen) begin
      e = exp_q.pop_front();
      check("reg_rdata", {8'h00, reg_rdata & e[15:8]}, {8'h00, e[7:0]});
    end
  end

  initial begin
    #400000;
    n_fail++;
    results();
  end

  initial begin
    void'($urandom(32'h1d06));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_KID, KID_RST, 8'hff);
    rd(OFS_KP, KP_RST, 8'hff);
    rd(OFS_KI, KI_RST, 8'hff);
    rd(OFS_KMC, 8'h19, 8'hff);
    rd(OFS_CTRL0, 8'h02, 8'hff);
    rd(OFS_CTRL1, 8'h00, 8'hff);
    wr(OFS_RSVD, 8'hff);
    wr(4'hf, 8'hff);
    rd(OFS_RSVD, 8'h00, 8'hff);
    rd(4'hf, 8'h00, 8'hff);
    wr(OFS_CTRL1, 8'hff);
    rd(OFS_CTRL1, 8'h1f, 8'hff);
    wr(OFS_CTRL1, 8'h00);
    for (i = 0; i < 4; i++) begin
      gv[i] = 8'($urandom);
      wr(4'(i), gv[i]);
      rd(4'(i), gv[i], 8'hff);
    end
    // Direct override, including both clamp edges and two random codes.
    li.speed <= 11'sd500;
    wr(OFS_CTRL0, 8'h0a);
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? -50 : (i == 1) ? 277 : (i == 2) ? 1023 : 277 + int'($urandom % 747);
      li.ref_post <= 11'(v);
      ticks(2);
      ea = (v < 277) ? 10'd277 : 10'(v);
      check("angle", 16'(gate_out.angle), 16'(ea));
      check("lockout_output", 16'(lockout_output), 16'd1);
      rd(OFS_ANG_LO, ea[7:0], 8'hff);
      rd(OFS_ANG_HI, {6'h00, ea[9:8]}, 8'hff);
    end
    // Inhibit overrides direct firing and holds the ramps.
    wr(OFS_CTRL0, 8'h0b);
    ticks(2);
    k = fire_cnt;
    ticks(3);
    check("angle", 16'(gate_out.angle), 16'd277);
    check("fire", 16'({gate_out.fire_b1, gate_out.fire_b2}), 16'd0);
    check("ramp_reset", 16'(gate_out.ramp_reset), 16'd1);
    check("fire_cnt", 16'(fire_cnt - k), 16'd0);
    wr(OFS_CTRL0, 8'h02);
    ticks(1);
    check("ramp_reset", 16'(gate_out.ramp_reset), 16'd0);
    // Standstill: stop command, then zero reference under both trigger modes.
    li.speed <= 11'sd5;
    li.stop_cmd <= 1'b1;
    ticks(6);
    check("angle", 16'(gate_out.angle), 16'd277);
    check("fire", 16'({gate_out.fire_b1, gate_out.fire_b2}), 16'd0);
    rd(OFS_STAT, 8'h10, 8'h10);
    li.stop_cmd <= 1'b0;
    li.zero_ref <= 1'b1;
    wr(OFS_CTRL0, 8'h06);
    ticks(3);
    rd(OFS_STAT, 8'h00, 8'h10);
    wr(OFS_CTRL0, 8'h02);
    ticks(6);
    rd(OFS_STAT, 8'h10, 8'h10);
    li.zero_ref <= 1'b0;
    li.speed <= 11'sd500;
    // Continuous autotune must leave the continuous integral gain alone.
    li.demand <= 11'sd600;
    li.fb <= 11'sd200;
    wr(OFS_CTRL1, 8'h02);
    ticks(10);
    rd(OFS_KI, gv[2], 8'hff);
    li.spillover <= 1'b1;
    wr(OFS_KP, 8'h40);
    ticks(3);
    rd(OFS_KP, 8'h40, 8'hff);
    li.spillover <= 1'b0;
    wr(OFS_CTRL1, 8'h00);
    // Series setting is taken at cyclic reset, cleared if bridge 2 is on.
    for (i = 0; i < 2; i++) begin
      li.b2_quadrant <= i[0];
      wr(OFS_CTRL0, 8'h42);
      li.cyclic_reset <= 1'b1;
      @(posedge clk_sys);
      li.cyclic_reset <= 1'b0;
      ticks(1);
      check("fire_delayed", 16'(gate_out.fire_delayed), i[0] ? 16'd0 : 16'd1);
      rd(OFS_STAT, {7'h00, ~i[0]}, 8'h01);
      rd(OFS_CTRL0, i[0] ? 8'h02 : 8'h42, 8'hff);
    end
    li.b2_quadrant <= 1'b0;
    wr(OFS_CTRL0, 8'h02);
    // Writes are not taken while the clock enable is low.
    clk_en <= 1'b0;
    wr(OFS_KMC, ~gv[3]);
    clk_en <= 1'b1;
    rd(OFS_KMC, gv[3], 8'hff);
    // Bridge changeover: partner lockout, the swap, then hysteresis and the swap back.
    li.demand <= -11'sd100;
    li.fb <= 11'sd50;
    ticks(2);
    check("fire", 16'({gate_out.fire_b1, gate_out.fire_b2}), 16'd0);
    check("lockout_output", 16'(lockout_output), 16'd0);
    rd(OFS_STAT, 8'h04, 8'h06);
    partner_busy <= 1'b1;
    wr(OFS_CTRL0, 8'h92);
    li.fb <= 11'sd0;
    ticks(3);
    rd(OFS_STAT, 8'h04, 8'h06);
    partner_busy <= 1'b0;
    ticks(4);
    rd(OFS_STAT, 8'h02, 8'h06);
    check("fire_b2", 16'(gate_out.fire_b2), 16'd1);
    li.demand <= 11'sd10;
    ticks(2);
    rd(OFS_STAT, 8'h02, 8'h06);
    wr(OFS_CTRL1, 8'h05);
    ticks(5);
    rd(OFS_STAT, 8'h00, 8'h06);
    li.demand <= 11'sd0;
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL0, 8'h02);
    // Both loop algorithms with known gains and cleared integrators.
    wr(OFS_KID, 8'h00);
    wr(OFS_KI, 8'h00);
    wr(OFS_KP, 8'h40);
    wr(OFS_KMC, 8'h40);
    li.demand <= 11'sd100;
    wr(OFS_CTRL0, 8'h03);
    ticks(1);
    wr(OFS_CTRL0, 8'h02);
    ticks(2);
    check("angle", 16'(gate_out.angle), 16'd477);
    wr(OFS_CTRL0, 8'h22);
    ticks(2);
    check("angle", 16'(gate_out.angle), 16'd302);
    li.fb <= 11'sd80;
    wr(OFS_CTRL1, 8'h08);
    ticks(2);
    check("angle", 16'(gate_out.angle), 16'd289);
    li.demand <= 11'sd0;
    li.fb <= 11'sd0;
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL0, 8'h02);
    // Start-up autotune loads gains and opens the relay for the set count.
    for (i = 0; i < 4; i++) begin
      gv[i] = 8'($urandom);
    end
    li.at_kid <= gv[0];
    li.at_kp <= gv[1];
    li.at_ki <= gv[2];
    li.at_kmc <= gv[3];
    wr(OFS_CTRL1, 8'h10);
    li.autotune_done <= 1'b1;
    @(posedge clk_sys);
    li.autotune_done <= 1'b0;
    for (k = 0; k < 10 && !gate_out.relay_open; k++) @(posedge clk_sys);
    for (k = 0; k < 100 && gate_out.relay_open; k++) @(posedge clk_sys);
    check("relay_cycles", 16'(k), 16'd20);
    rd(OFS_CTRL1, 8'h00, 8'hff);
    for (i = 0; i < 4; i++) begin
      rd(4'(i), gv[i], 8'hff);
    end
    repeat (4) @(posedge clk_sys);
    results();
  end
endmodule
